// file: rtl/cscc_defines.svh
`ifndef CSCC_DEFINES_SVH
`define CSCC_DEFINES_SVH

`define CSCC_RETRY_INIT 2'h3
`define CSCC_UNLOCK_INIT 4'hA
`define CSCC_LC_EMPTY 8'h00
`define CSCC_LC_ONE 8'h08
`define CSCC_LC_TWO 8'h10
`define CSCC_SW_OK 16'h9000
`define CSCC_SW_RETRY 16'h63C0
`define CSCC_SW_BLOCKED 16'h6983
`define CSCC_SW_UNUSABLE 16'h6984
`define CSCC_SW_BAD_LEN 16'h6700
`define CSCC_SW_BAD_P2 16'h6A86
`define CSCC_SW_BAD_INS 16'h6D00
`define CSCC_P2_SPECIFIC 7
`define CSCC_OFF_CTRL 8'h00
`define CSCC_OFF_DATA0 8'h04
`define CSCC_OFF_DATA1 8'h08
`define CSCC_OFF_DATA2 8'h0C
`define CSCC_OFF_DATA3 8'h10
`define CSCC_OFF_STATUS 8'h14
`define CSCC_CTRL_GO 31
`define CSCC_CTRL_SPEC 9
`define CSCC_CTRL_EMPTY 2

`endif

// file: rtl/cscc_pkg.sv
package cscc_pkg;
   typedef enum logic [1:0] {
      CSCC_INS_VERIFY = 2'h0,
      CSCC_INS_CHANGE = 2'h1,
      CSCC_INS_UNLOCK = 2'h2,
      CSCC_INS_NONE = 2'h3
   } cscc_ins_type;
   typedef enum logic [1:0] {
      CSCC_S_IDLE = 2'h1,
      CSCC_S_EXEC = 2'h2
   } cscc_card_state_type;
   typedef enum logic [2:0] {
      CSCC_T_IDLE = 3'h1,
      CSCC_T_REQ = 3'h2,
      CSCC_T_WAIT = 3'h4
   } cscc_term_state_type;
endpackage

// file: rtl/cscc_link_if.sv
`timescale 1ns/1ps
interface cscc_link_if;
   logic req_valid;
   logic req_ready;
   cscc_pkg::cscc_ins_type req_ins;
   logic [7:0] req_p2;
   logic [7:0] req_lc;
   logic [127:0] req_data;
   logic resp_valid;
   logic [15:0] resp_sw;
   modport card (
      input req_valid,
      output req_ready,
      input req_ins,
      input req_p2,
      input req_lc,
      input req_data,
      output resp_valid,
      output resp_sw
   );
   modport term (
      output req_valid,
      input req_ready,
      output req_ins,
      output req_p2,
      output req_lc,
      output req_data,
      input resp_valid,
      input resp_sw
   );
endinterface

// file: rtl/cscc_card.sv
`timescale 1ns/1ps
`include "cscc_defines.svh"
module cscc_card #(
   parameter int NUM_CODES = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic session_rst,
   cscc_link_if.card link,
   input wire logic prov_we,
   input wire logic [$clog2(NUM_CODES)-1:0] prov_idx,
   input wire logic [63:0] prov_code,
   input wire logic [63:0] prov_unlock_code,
   input wire logic [NUM_CODES-1:0] code_disabled,
   input wire logic [NUM_CODES-1:0] alt_key_set,
   input wire logic [$clog2(NUM_CODES)-1:0] alt_key_idx,
   input wire logic [$clog2(NUM_CODES)-1:0] acc_idx,
   output logic acc_granted,
   output logic [NUM_CODES-1:0] code_blocked
);
   localparam int IDX_W = $clog2(NUM_CODES);

   // Selects the stored code; bit 7 picks the global or specific half
   function automatic logic [IDX_W-1:0] code_index(input logic [7:0] p2);
      logic [IDX_W-1:0] idx;
      idx = p2[IDX_W-1:0];
      idx[IDX_W-1] = p2[`CSCC_P2_SPECIFIC];
      return idx;
   endfunction

   // Rejects reserved bits, the all-zero reference and unstored numbers
   function automatic logic ref_ok(input logic [7:0] p2);
      logic [4:0] num;
      num = p2[4:0];
      ref_ok = (p2[6:5] == 2'h0) && (num != 5'h00)
         && ((num >> (IDX_W - 1)) == 5'h00);
   endfunction

   function automatic logic [15:0] retry_sw(input logic [1:0] left);
      retry_sw = `CSCC_SW_RETRY | {14'h0000, left};
   endfunction

   cscc_pkg::cscc_card_state_type state;
   cscc_pkg::cscc_card_state_type next_state;
   cscc_pkg::cscc_ins_type cur_ins;
   cscc_pkg::cscc_ins_type next_cur_ins;
   logic [7:0] cur_p2;
   logic [7:0] next_cur_p2;
   logic [7:0] cur_lc;
   logic [7:0] next_cur_lc;
   logic [127:0] cur_data;
   logic [127:0] next_cur_data;
   logic [63:0] ref_code [NUM_CODES];
   logic [63:0] next_ref_code [NUM_CODES];
   logic [63:0] unlock_code [NUM_CODES];
   logic [63:0] next_unlock_code [NUM_CODES];
   logic [1:0] retry [NUM_CODES];
   logic [1:0] next_retry [NUM_CODES];
   logic [3:0] unlock_left [NUM_CODES];
   logic [3:0] next_unlock_left [NUM_CODES];
   logic [NUM_CODES-1:0] next_code_blocked;
   logic [NUM_CODES-1:0] verified;
   logic [NUM_CODES-1:0] next_verified;
   logic resp_valid;
   logic next_resp_valid;
   logic [15:0] resp_sw;
   logic [15:0] next_resp_sw;
   logic next_acc_granted;
   logic [IDX_W-1:0] idx;
   logic [63:0] old_code;
   logic [63:0] new_code;
   logic [1:0] dec_retry;

   assign link.req_ready = (state == cscc_pkg::CSCC_S_IDLE);
   assign link.resp_valid = resp_valid;
   assign link.resp_sw = resp_sw;
   assign idx = code_index(cur_p2);
   assign old_code = cur_data[127:64];
   assign new_code = cur_data[63:0];
   assign dec_retry = retry[idx] - 2'h1;

   always_comb begin
      next_state = state;
      next_cur_ins = cur_ins;
      next_cur_p2 = cur_p2;
      next_cur_lc = cur_lc;
      next_cur_data = cur_data;
      next_ref_code = ref_code;
      next_unlock_code = unlock_code;
      next_retry = retry;
      next_unlock_left = unlock_left;
      next_code_blocked = code_blocked;
      next_verified = verified;
      next_resp_valid = 1'b0;
      next_resp_sw = resp_sw;
      // Session reset only drops security status, not the counters
      if (session_rst) begin
         next_verified = '0;
      end
      // Provisioning loads fresh values and restores the counters
      if (prov_we) begin
         next_ref_code[prov_idx] = prov_code;
         next_unlock_code[prov_idx] = prov_unlock_code;
         next_retry[prov_idx] = `CSCC_RETRY_INIT;
         next_unlock_left[prov_idx] = `CSCC_UNLOCK_INIT;
         next_code_blocked[prov_idx] = 1'b0;
         next_verified[prov_idx] = 1'b0;
      end
      case (state)
         cscc_pkg::CSCC_S_IDLE: begin
            if (link.req_valid) begin
               next_cur_ins = link.req_ins;
               next_cur_p2 = link.req_p2;
               next_cur_lc = link.req_lc;
               next_cur_data = link.req_data;
               next_state = cscc_pkg::CSCC_S_EXEC;
            end
         end
         cscc_pkg::CSCC_S_EXEC: begin
            next_state = cscc_pkg::CSCC_S_IDLE;
            next_resp_valid = 1'b1;
            if (!ref_ok(cur_p2)) begin
               next_resp_sw = `CSCC_SW_BAD_P2;
            end else begin
               case (cur_ins)
                  cscc_pkg::CSCC_INS_VERIFY: begin
                     if (cur_lc == `CSCC_LC_EMPTY) begin
                        if (code_blocked[idx]) begin
                           next_resp_sw = `CSCC_SW_BLOCKED;
                        end else begin
                           next_resp_sw = retry_sw(retry[idx]);
                        end
                     end else if (cur_lc != `CSCC_LC_ONE) begin
                        next_resp_sw = `CSCC_SW_BAD_LEN;
                     end else if (code_disabled[idx]) begin
                        next_resp_sw = `CSCC_SW_UNUSABLE;
                     end else if (code_blocked[idx]) begin
                        next_resp_sw = `CSCC_SW_BLOCKED;
                     end else if (old_code == ref_code[idx]) begin
                        next_retry[idx] = `CSCC_RETRY_INIT;
                        next_verified[idx] = 1'b1;
                        next_resp_sw = `CSCC_SW_OK;
                     end else begin
                        next_retry[idx] = dec_retry;
                        next_verified[idx] = 1'b0;
                        next_code_blocked[idx] = (dec_retry == 2'h0);
                        next_resp_sw = retry_sw(dec_retry);
                     end
                  end
                  cscc_pkg::CSCC_INS_CHANGE: begin
                     if (cur_lc != `CSCC_LC_TWO) begin
                        next_resp_sw = `CSCC_SW_BAD_LEN;
                     end else if (code_disabled[idx]) begin
                        next_resp_sw = `CSCC_SW_UNUSABLE;
                     end else if (code_blocked[idx]) begin
                        next_resp_sw = `CSCC_SW_BLOCKED;
                     end else if (old_code == ref_code[idx]) begin
                        next_retry[idx] = `CSCC_RETRY_INIT;
                        next_ref_code[idx] = new_code;
                        next_resp_sw = `CSCC_SW_OK;
                     end else begin
                        // Stored value stays as it was
                        next_retry[idx] = dec_retry;
                        next_verified[idx] = 1'b0;
                        next_code_blocked[idx] = (dec_retry == 2'h0);
                        next_resp_sw = retry_sw(dec_retry);
                     end
                  end
                  cscc_pkg::CSCC_INS_UNLOCK: begin
                     if (cur_lc != `CSCC_LC_TWO) begin
                        next_resp_sw = `CSCC_SW_BAD_LEN;
                     end else if (unlock_left[idx] == 4'h0) begin
                        next_resp_sw = `CSCC_SW_BLOCKED;
                     end else if (old_code == unlock_code[idx]) begin
                        next_ref_code[idx] = new_code;
                        next_retry[idx] = `CSCC_RETRY_INIT;
                        next_unlock_left[idx] = `CSCC_UNLOCK_INIT;
                        next_code_blocked[idx] = 1'b0;
                        next_verified[idx] = 1'b1;
                        next_resp_sw = `CSCC_SW_OK;
                     end else begin
                        next_unlock_left[idx] = unlock_left[idx] - 4'h1;
                        next_resp_sw = `CSCC_SW_RETRY
                           | {12'h000, unlock_left[idx] - 4'h1};
                     end
                  end
                  default: begin
                     next_resp_sw = `CSCC_SW_BAD_INS;
                  end
               endcase
            end
         end
         default: begin
            next_state = cscc_pkg::CSCC_S_IDLE;
         end
      endcase
      // A disabled code frees its files unless an alternative key stands in
      if (code_disabled[acc_idx]) begin
         next_acc_granted = !alt_key_set[acc_idx]
            || verified[alt_key_idx];
      end else begin
         next_acc_granted = verified[acc_idx]
            && !code_blocked[acc_idx];
      end
   end

   // Counters and blocked flags take their initial values at power-on and again on provisioning;
   // the session input leaves them alone and clears only the verified flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= cscc_pkg::CSCC_S_IDLE;
         cur_ins <= cscc_pkg::CSCC_INS_NONE;
         cur_p2 <= 8'h00;
         cur_lc <= 8'h00;
         cur_data <= 128'h0;
         for (int i = 0; i < NUM_CODES; i++) begin
            ref_code[i] <= 64'h0;
            unlock_code[i] <= 64'h0;
            retry[i] <= `CSCC_RETRY_INIT;
            unlock_left[i] <= `CSCC_UNLOCK_INIT;
         end
         code_blocked <= '0;
         verified <= '0;
         resp_valid <= 1'b0;
         resp_sw <= 16'h0000;
         acc_granted <= 1'b0;
      end else begin
         state <= next_state;
         cur_ins <= next_cur_ins;
         cur_p2 <= next_cur_p2;
         cur_lc <= next_cur_lc;
         cur_data <= next_cur_data;
         ref_code <= next_ref_code;
         unlock_code <= next_unlock_code;
         retry <= next_retry;
         unlock_left <= next_unlock_left;
         code_blocked <= next_code_blocked;
         verified <= next_verified;
         resp_valid <= next_resp_valid;
         resp_sw <= next_resp_sw;
         acc_granted <= next_acc_granted;
      end
   end
endmodule

// file: rtl/cscc_term.sv
`timescale 1ns/1ps
`include "cscc_defines.svh"
module cscc_term (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   cscc_link_if.term link
);
   cscc_pkg::cscc_term_state_type state;
   cscc_pkg::cscc_term_state_type next_state;
   logic [31:0] ctrl;
   logic [31:0] next_ctrl;
   logic [31:0] data [4];
   logic [31:0] next_data [4];
   logic done;
   logic next_done;
   logic param_err;
   logic next_param_err;
   logic [15:0] last_sw;
   logic [15:0] next_last_sw;
   logic [7:0] p2;
   logic [7:0] next_p2;
   logic [7:0] lc;
   logic [7:0] next_lc;
   logic wr;
   logic mapped;
   logic go;

   assign wr = psel && penable && pwrite;
   assign mapped = (paddr <= `CSCC_OFF_STATUS) && (paddr[1:0] == 2'h0);
   assign go = wr && (paddr == `CSCC_OFF_CTRL) && pwdata[`CSCC_CTRL_GO];
   // Registers answer at once, so the access phase is a single cycle
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign link.req_valid = (state == cscc_pkg::CSCC_T_REQ);
   assign link.req_ins = cscc_pkg::cscc_ins_type'(ctrl[1:0]);
   assign link.req_p2 = p2;
   assign link.req_lc = lc;
   assign link.req_data = {data[0], data[1], data[2], data[3]};

   always_comb begin
      prdata = 32'h0000_0000;
      case (paddr)
         `CSCC_OFF_CTRL: prdata = {1'b0, ctrl[30:0]};
         `CSCC_OFF_DATA0: prdata = data[0];
         `CSCC_OFF_DATA1: prdata = data[1];
         `CSCC_OFF_DATA2: prdata = data[2];
         `CSCC_OFF_DATA3: prdata = data[3];
         `CSCC_OFF_STATUS: prdata = {last_sw, 13'h0000, param_err,
            (state != cscc_pkg::CSCC_T_IDLE), done};
         default: prdata = 32'h0000_0000;
      endcase
   end

   always_comb begin
      next_state = state;
      next_ctrl = ctrl;
      next_data = data;
      next_done = done;
      next_param_err = param_err;
      next_last_sw = last_sw;
      next_p2 = p2;
      next_lc = lc;
      // Writes are refused while a command is in flight
      if (wr && state == cscc_pkg::CSCC_T_IDLE) begin
         for (int i = 0; i < 4; i++) begin
            if (paddr == `CSCC_OFF_DATA0 + 8'(4 * i)) begin
               next_data[i] = pwdata;
            end
         end
         if (paddr == `CSCC_OFF_CTRL) begin
            next_ctrl = pwdata;
         end
      end
      case (state)
         cscc_pkg::CSCC_T_IDLE: begin
            if (go) begin
               next_done = 1'b0;
               next_p2 = {pwdata[`CSCC_CTRL_SPEC], 2'h0,
                  pwdata[8:4]};
               if (pwdata[8:4] == 5'h00) begin
                  next_param_err = 1'b1;
               end else begin
                  next_param_err = 1'b0;
                  next_state = cscc_pkg::CSCC_T_REQ;
               end
               if (pwdata[1:0] == 2'(cscc_pkg::CSCC_INS_VERIFY)) begin
                  next_lc = pwdata[`CSCC_CTRL_EMPTY] ? `CSCC_LC_EMPTY
                     : `CSCC_LC_ONE;
               end else begin
                  next_lc = `CSCC_LC_TWO;
               end
            end
         end
         cscc_pkg::CSCC_T_REQ: begin
            if (link.req_ready) begin
               next_state = cscc_pkg::CSCC_T_WAIT;
            end
         end
         cscc_pkg::CSCC_T_WAIT: begin
            if (link.resp_valid) begin
               next_last_sw = link.resp_sw;
               next_done = 1'b1;
               next_state = cscc_pkg::CSCC_T_IDLE;
            end
         end
         default: begin
            next_state = cscc_pkg::CSCC_T_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= cscc_pkg::CSCC_T_IDLE;
         ctrl <= 32'h0000_0000;
         for (int i = 0; i < 4; i++) begin
            data[i] <= 32'h0000_0000;
         end
         done <= 1'b0;
         param_err <= 1'b0;
         last_sw <= 16'h0000;
         p2 <= 8'h00;
         lc <= 8'h00;
      end else begin
         state <= next_state;
         ctrl <= next_ctrl;
         data <= next_data;
         done <= next_done;
         param_err <= next_param_err;
         last_sw <= next_last_sw;
         p2 <= next_p2;
         lc <= next_lc;
      end
   end
endmodule

// file: verif/cscc_properties.sv
`timescale 1ns/1ps
module cscc_properties (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire cscc_pkg::cscc_ins_type req_ins,
   input wire logic [7:0] req_p2,
   input wire logic [7:0] req_lc,
   input wire logic resp_valid,
   input wire logic [15:0] resp_sw
);
   logic take;
   cscc_pkg::cscc_ins_type ins_q;
   cscc_pkg::cscc_ins_type next_ins_q;
   logic [7:0] p2_q;
   logic [7:0] next_p2_q;
   // Command fields are latched at the take, since the far end may move on
   assign take = req_valid && req_ready;
   always_comb begin
      next_ins_q = take ? req_ins : ins_q;
      next_p2_q = take ? req_p2 : p2_q;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ins_q <= cscc_pkg::CSCC_INS_NONE;
         p2_q <= 8'h00;
      end else begin
         ins_q <= next_ins_q;
         p2_q <= next_p2_q;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_answer_two_edges: assert property (take |-> ##2 resp_valid)
      else $error("answer not two edges after take");
   chk_busy_exec: assert property (take |=> !req_ready)
      else $error("card ready while executing");
   chk_answer_pulse: assert property (resp_valid |=> !resp_valid)
      else $error("answer strobe longer than one cycle");
   chk_sw_holds: assert property (!resp_valid |-> $stable(resp_sw))
      else $error("status word moved without answer");
   chk_answer_caused: assert property (resp_valid |-> $past(take, 2))
      else $error("answer without a command");
   chk_bad_ins: assert property (resp_valid && p2_q[6:0] == 7'h01 &&
      ins_q == cscc_pkg::CSCC_INS_NONE |-> resp_sw == 16'h6D00)
      else $error("unknown instruction not refused");
   chk_bad_ref: assert property (resp_valid && p2_q[4:1] != 4'h0 &&
      ins_q != cscc_pkg::CSCC_INS_NONE |-> resp_sw == 16'h6A86)
      else $error("unsupported reference not refused");
   chk_retry_limit: assert property (resp_valid &&
      ins_q != cscc_pkg::CSCC_INS_UNLOCK && resp_sw[15:4] == 12'h63C
      |-> resp_sw[3:0] <= 4'h3)
      else $error("retry count above three");
   chk_p2_shape: assert property (take |->
      req_p2[6:5] == 2'b00 && req_p2[4:0] != 5'h00)
      else $error("bad second parameter byte offered");
   chk_change_len: assert property (take &&
      req_ins == cscc_pkg::CSCC_INS_CHANGE |-> req_lc == 8'h10)
      else $error("change length not 10");
   cover property (resp_valid && resp_sw == 16'h9000);
   cover property (resp_valid && resp_sw == 16'h6983);
   cover property (take && req_ins == cscc_pkg::CSCC_INS_CHANGE);
endmodule

// file: verif/card_secret_code_check_tb_top.sv
`timescale 1ns/1ps
module card_secret_code_check_tb_top;
   localparam logic [63:0] KA = 64'h0123456789ABCDEF;
   localparam logic [63:0] KB = 64'hFEDCBA9876543210;
   localparam logic [63:0] KU = 64'h5A5A5A5A5A5A5A5A;
   localparam logic [63:0] KN = 64'h0F1E2D3C4B5A6978;
   localparam logic [127:0] Z = 128'h0;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic session_rst, prov_we, acc_granted, slv_err;
   logic [7:0] paddr, t_p2, t_lc;
   logic [31:0] pwdata, prdata, rdv;
   logic [1:0] prov_idx, alt_key_idx, acc_idx;
   logic [63:0] prov_code, prov_unlock_code;
   logic [3:0] code_disabled, alt_key_set, code_blocked;
   logic [127:0] t_data;
   int fails, tests_run;
   cscc_link_if link();
   cscc_card #(.NUM_CODES(4)) u_cscc_card (.pclk(pclk), .presetn(presetn),
      .session_rst(session_rst), .link(link), .prov_we(prov_we),
      .prov_idx(prov_idx), .prov_code(prov_code),
      .prov_unlock_code(prov_unlock_code), .code_disabled(code_disabled),
      .alt_key_set(alt_key_set), .alt_key_idx(alt_key_idx),
      .acc_idx(acc_idx), .acc_granted(acc_granted),
      .code_blocked(code_blocked));
   cscc_term u_cscc_term (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
   cscc_properties u_cscc_properties (.pclk(pclk), .presetn(presetn),
      .req_valid(link.req_valid), .req_ready(link.req_ready),
      .req_ins(link.req_ins), .req_p2(link.req_p2), .req_lc(link.req_lc),
      .resp_valid(link.resp_valid), .resp_sw(link.resp_sw));
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   // Wire view of each command as the card takes it
   always @(posedge pclk) begin
      if (link.req_valid === 1'b1 && link.req_ready === 1'b1) begin
         t_p2 = link.req_p2;
         t_lc = link.req_lc;
         t_data = link.req_data;
      end
   end
   task automatic chk(input string nm, input logic [31:0] s, e);
      tests_run++;
      if (s !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
         fails++;
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Waits as long as the slave stalls; only the watchdog ends it
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdv = prdata;
      slv_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Control bits: [9] specific, [8:4] ref, [2] empty, [1:0] instruction
   task automatic cmd(input logic [9:0] c, input logic [127:0] d,
         input logic [15:0] e);
      for (int i = 0; i < 4; i++) apb(1'b1, 8'(4 + 4 * i), d[127-32*i -: 32]);
      apb(1'b1, 8'h00, {1'b1, 21'h0, c});
      rdv = 32'h0;
      while (rdv[0] !== 1'b1) begin
         apb(1'b0, 8'h14, 32'h0);
      end
      chk("status word", 32'(rdv[31:16]), 32'(e));
   endtask
   task automatic acc(input logic [1:0] i, input logic e);
      acc_idx <= i;
      repeat (2) @(posedge pclk);
      chk("access", 32'(acc_granted), 32'(e));
   endtask
   task automatic new_session();
      @(posedge pclk);
      session_rst <= 1'b1;
      @(posedge pclk);
      session_rst <= 1'b0;
   endtask
   task automatic t_retry();
      cmd(10'h014, Z, 16'h63C3);
      cmd(10'h010, {KB, 64'h0}, 16'h63C2);
      cmd(10'h014, Z, 16'h63C2);
      cmd(10'h010, {KB, 64'h0}, 16'h63C1);
      cmd(10'h010, {KA, 64'h0}, 16'h9000);
      cmd(10'h014, Z, 16'h63C3);
      for (int i = 0; i < 3; i++) begin
         cmd(10'h010, {KB, 64'h0}, 16'(16'h63C2 - i));
      end
      chk("blocked", 32'(code_blocked), 32'h2);
      cmd(10'h010, {KA, 64'h0}, 16'h6983);
      cmd(10'h014, Z, 16'h6983);
      acc(2'h1, 1'b0);
      new_session();
      cmd(10'h014, Z, 16'h6983);
      chk("blocked kept", 32'(code_blocked), 32'h2);
   endtask
   task automatic t_unlock();
      cmd(10'h012, {KB, KN}, 16'h63C9);
      chk("still blocked", 32'(code_blocked), 32'h2);
      cmd(10'h012, {KU, KN}, 16'h9000);
      chk("unblocked", 32'(code_blocked), 32'h0);
      acc(2'h1, 1'b1);
      cmd(10'h014, Z, 16'h63C3);
      cmd(10'h010, {KN, 64'h0}, 16'h9000);
   endtask
   task automatic t_change();
      cmd(10'h211, {KB, KN}, 16'h63C2);
      chk("lc", 32'(t_lc), 32'h10);
      chk("p2", 32'(t_p2), 32'h81);
      chk("data", 32'(t_data == {KB, KN}), 32'h1);
      cmd(10'h210, {KA, 64'h0}, 16'h9000);
      cmd(10'h211, {KA, KN}, 16'h9000);
      cmd(10'h214, Z, 16'h63C3);
      cmd(10'h210, {KA, 64'h0}, 16'h63C2);
      cmd(10'h210, {KN, 64'h0}, 16'h9000);
      for (int i = 0; i < 3; i++) begin
         cmd(10'h211, {KB, KA}, 16'(16'h63C2 - i));
      end
      chk("blocked", 32'(code_blocked), 32'h8);
      cmd(10'h211, {KN, KA}, 16'h6983);
      cmd(10'h212, {KU, KA}, 16'h9000);
   endtask
   task automatic t_disabled();
      new_session();
      acc(2'h3, 1'b0);
      code_disabled <= 4'h8;
      acc(2'h3, 1'b1);
      cmd(10'h210, {KA, 64'h0}, 16'h6984);
      cmd(10'h211, {KA, KB}, 16'h6984);
      cmd(10'h214, Z, 16'h63C3);
      alt_key_set <= 4'h8;
      alt_key_idx <= 2'h1;
      acc(2'h3, 1'b0);
      cmd(10'h010, {KN, 64'h0}, 16'h9000);
      acc(2'h3, 1'b1);
      code_disabled <= 4'h0;
      alt_key_set <= 4'h0;
      acc(2'h3, 1'b0);
      cmd(10'h210, {KA, 64'h0}, 16'h9000);
      acc(2'h3, 1'b1);
   endtask
   task automatic t_params();
      cmd(10'h020, Z, 16'h6A86);
      cmd(10'h013, Z, 16'h6D00);
      apb(1'b1, 8'h00, 32'h80000000);
      apb(1'b0, 8'h14, 32'h0);
      chk("ref zero", 32'(rdv[2]), 32'h1);
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped", 32'(slv_err), 32'h1);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      fails++;
      conclude();
   end
   initial begin
      {presetn, psel, penable, pwrite, session_rst, prov_we} = 6'h0;
      {paddr, pwdata, prov_idx, alt_key_idx, acc_idx} = '0;
      {prov_code, prov_unlock_code, code_disabled, alt_key_set} = '0;
      fails = 0;
      tests_run = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 1; i < 4; i += 2) begin
         @(posedge pclk);
         prov_we <= 1'b1;
         prov_idx <= 2'(i);
         prov_code <= KA;
         prov_unlock_code <= KU;
         @(posedge pclk);
         prov_we <= 1'b0;
      end
      t_retry();
      $display("t_retry done");
      t_unlock();
      $display("t_unlock done");
      t_change();
      $display("t_change done");
      t_disabled();
      $display("t_disabled done");
      t_params();
      $display("t_params done");
      conclude();
   end
endmodule
